// ---- slpem_device.sv ----
/*
 * slpem_device: link parameter registers, deskew enables and three
 * per-lane 8b/10b error counters with threshold flags.
 * assumes: decoder error pulses on the interface, one per error per lane.
 */
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module slpem_device
    import slpem_pkg::*;
(
    // clock and reset
    input  wire logic  REF_CLK,
    input  wire logic  RST,
    // register link
    slpem_if.dev       LINK,
    // configuration out to the datapath
    output logic [7:0] CONV_MINUS_ONE,
    output logic [7:0] LANE_DESKEW,
    output logic       CHECKSUM_MODE
);
    logic [7:0] conv, csn, np, sreg, hdcf, spare1, spare2, chksum;
    logic [7:0] deskew, thresh, ckmode;
    logic [7:0] octets;
    logic [LSEL_HI-LSEL_LO:0] monitor_lane_select;
    logic [CSEL_HI-CSEL_LO:0] monitor_counter_select;
    logic [7:0] cnt [KINDS][LANES];
    logic [LANES-1:0] flags [KINDS];
    logic [LANES-1:0] cnt_off [KINDS];
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic [LANES-1:0] ev [KINDS];

    assign ev[0] = LINK.err_disp;
    assign ev[1] = LINK.err_nit;
    assign ev[2] = LINK.err_ucc;

    wire wr_at = LINK.wr;

    ////////////////////////////////////////////////////////////////////
    // link parameter registers
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            conv   <= RST_CONV;
            csn    <= RST_CSN;
            np     <= RST_NP;
            sreg   <= RST_S;
            // high density at reset, no control words
            hdcf   <= RST_HDCF;
            spare1 <= RST_ZERO;
            spare2 <= RST_ZERO;
            chksum <= RST_CHKSUM;
            deskew <= RST_DESKEW;
            thresh <= RST_THRESH;
            ckmode <= RST_ZERO;
        end else if (wr_at) begin
            unique case (LINK.addr)
                ADDR_CONV:   conv   <= LINK.wdata;
                ADDR_CSN:    csn    <= LINK.wdata & MASK_CSN;
                ADDR_NP:     np     <= LINK.wdata;
                ADDR_S:      sreg   <= LINK.wdata;
                ADDR_HDCF:   hdcf   <= LINK.wdata & MASK_HDCF;
                ADDR_SPARE1: spare1 <= LINK.wdata;
                ADDR_SPARE2: spare2 <= LINK.wdata;
                ADDR_CHKSUM: chksum <= LINK.wdata;
                ADDR_DESKEW: deskew <= LINK.wdata;
                ADDR_THRESH: thresh <= LINK.wdata;
                ADDR_CKMODE: ckmode <= LINK.wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // octets per lane per frame, count minus one
    // an illegal code is dropped so the framer never sees it
    wire octets_legal = LINK.wdata == OCT_ONE || LINK.wdata == OCT_TWO ||
                        LINK.wdata == OCT_FOUR;
    // only one, two or four octets
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            octets <= OCT_ONE;
        end else if (wr_at && LINK.addr == ADDR_OCTETS && octets_legal) begin
            octets <= LINK.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // monitor select, write only
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            monitor_lane_select    <= '0;
            monitor_counter_select <= '0;
        end else if (wr_at && LINK.addr == ADDR_MON) begin
            monitor_lane_select    <= LINK.wdata[LSEL_HI:LSEL_LO];
            monitor_counter_select <= LINK.wdata[CSEL_HI:CSEL_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // counters and flags per kind and lane
    for (genvar k = 0; k < KINDS; k++) begin : g_kind
        wire       ctl_hit = wr_at && LINK.addr == ADDR_DISP + 12'(k);
        wire [2:0] ctl_ln  = LINK.wdata[LADR_HI:LADR_LO];
        for (genvar l = 0; l < LANES; l++) begin : g_lane
            wire sel = ctl_hit && ctl_ln == 3'(l);
            always_ff @(posedge REF_CLK or posedge RST) begin
                if (RST) begin
                    cnt[k][l] <= RST_ZERO;
                end else if (sel && LINK.wdata[BIT_RST_CNT]) begin
                    cnt[k][l] <= RST_ZERO;
                end else if (ev[k][l] && !cnt_off[k][l] && cnt[k][l] != CNT_MAX) begin
                    cnt[k][l] <= cnt[k][l] + 8'h01;
                end
            end
            always_ff @(posedge REF_CLK or posedge RST) begin
                if (RST) begin
                    cnt_off[k][l] <= 1'b0;
                end else if (sel && LINK.wdata[BIT_DIS_CNT]) begin
                    cnt_off[k][l] <= 1'b1;
                end
            end
            // flag at threshold; same for other kinds
            always_ff @(posedge REF_CLK or posedge RST) begin
                if (RST) begin
                    flags[k][l] <= 1'b0;
                end else if (cnt[k][l] >= thresh) begin
                    flags[k][l] <= 1'b1;
                end else if (sel && LINK.wdata[BIT_RST_IRQ]) begin
                    flags[k][l] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path
    always_comb begin
        next_rdata = RST_ZERO;
        unique case (LINK.addr)
            ADDR_CONV:   next_rdata = conv;
            ADDR_CSN:    next_rdata = csn;
            ADDR_NP:     next_rdata = np;
            ADDR_S:      next_rdata = sreg;
            ADDR_HDCF:   next_rdata = hdcf;
            ADDR_SPARE1: next_rdata = spare1;
            ADDR_SPARE2: next_rdata = spare2;
            ADDR_CHKSUM: next_rdata = chksum;
            ADDR_MON:    next_rdata = (monitor_counter_select < 2'(KINDS))
                                      ? cnt[monitor_counter_select][monitor_lane_select]
                                      : RST_ZERO;
            ADDR_DESKEW: next_rdata = deskew;
            ADDR_DISP:   next_rdata = flags[0];
            ADDR_NIT:    next_rdata = flags[1];
            ADDR_UCC:    next_rdata = flags[2];
            ADDR_THRESH: next_rdata = thresh;
            ADDR_CKMODE: next_rdata = ckmode;
            ADDR_OCTETS: next_rdata = octets;
            default:     next_rdata = RST_ZERO;
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rdata <= RST_ZERO;
        end else begin
            rdata <= LINK.rd ? next_rdata : RST_ZERO;
        end
    end

    assign LINK.rdata     = rdata;
    assign LINK.irq       = |{flags[0], flags[1], flags[2]};
    assign CONV_MINUS_ONE = conv;
    assign LANE_DESKEW    = deskew;
    assign CHECKSUM_MODE  = ckmode[BIT_CKMODE];
endmodule : slpem_device
`default_nettype wire

// ---- slpem_host.sv ----
/*
 * slpem_host: controller that configures the receiver block and reads
 * it back, ordered through its own small register port.
 * assumes: device answers a read in the cycle after the read strobe.
 */
`timescale 1ns/1ns
`default_nettype none
module slpem_host
    import slpem_pkg::*;
(
    // clock and reset
    input  wire logic       REF_CLK,
    input  wire logic       RST,
    // software port
    input  wire logic [3:0] SW_ADDR,
    input  wire logic [7:0] SW_WDATA,
    input  wire logic       SW_WR,
    input  wire logic       SW_RD,
    output logic      [7:0] SW_RDATA,
    output logic            IRQ,
    // device side
    slpem_if.host           LINK
);
    typedef enum {SLPEM_IDLE, SLPEM_WAIT} slpem_state_t;
    slpem_state_t state;
    logic [11:0] tgt;
    logic [7:0]  wd, rbuf, sw_rdata;
    logic [1:0]  status, mask;
    logic        wr_o, rd_o;

    ////////////////////////////////////////////////////////////////////
    // software registers; status bit0 write done, bit1 read done
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            tgt  <= '0;
            wd   <= RST_ZERO;
            mask <= '0;
        end else if (SW_WR) begin
            unique case (SW_ADDR)
                H_WDATA:  wd   <= SW_WDATA;
                H_ADDR_L: tgt[7:0]  <= SW_WDATA;
                H_ADDR_H: tgt[11:8] <= SW_WDATA[3:0];
                H_MASK:   mask <= SW_WDATA[1:0];
                default: ;
            endcase
        end
    end

    // a write command while one is on the link is dropped: wr stays one cycle
    wire go_wr = SW_WR && SW_ADDR == H_CMD && SW_WDATA[1:0] == CMD_WR && state == SLPEM_IDLE
                 && !wr_o;
    wire go_rd = SW_WR && SW_ADDR == H_CMD && SW_WDATA[1:0] == CMD_RD && state == SLPEM_IDLE;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state <= SLPEM_IDLE;
            wr_o  <= 1'b0;
            rd_o  <= 1'b0;
            rbuf  <= RST_ZERO;
        end else begin
            wr_o <= go_wr;
            rd_o <= go_rd;
            unique case (state)
                SLPEM_IDLE: if (go_rd) state <= SLPEM_WAIT;
                SLPEM_WAIT: if (!rd_o) begin
                    rbuf  <= LINK.rdata;
                    state <= SLPEM_IDLE;
                end
            endcase
        end
    end

    // done events; set wins over a write-one clear
    wire [1:0] ev = {state == SLPEM_WAIT && !rd_o, wr_o};
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            status <= '0;
        end else begin
            status <= (status & ~((SW_WR && SW_ADDR == H_STATUS) ? SW_WDATA[1:0] : 2'h0)) | ev;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            sw_rdata <= RST_ZERO;
        end else if (SW_RD) begin
            unique case (SW_ADDR)
                H_WDATA:  sw_rdata <= wd;
                H_ADDR_L: sw_rdata <= tgt[7:0];
                H_ADDR_H: sw_rdata <= {4'h0, tgt[11:8]};
                H_RDATA:  sw_rdata <= rbuf;
                H_STATUS: sw_rdata <= {5'h0, LINK.irq, status};
                H_MASK:   sw_rdata <= {6'h0, mask};
                default:  sw_rdata <= RST_ZERO;
            endcase
        end else begin
            sw_rdata <= RST_ZERO;
        end
    end

    assign LINK.addr  = tgt;
    assign LINK.wdata = wd;
    assign LINK.wr    = wr_o;
    assign LINK.rd    = rd_o;
    assign SW_RDATA   = sw_rdata;
    assign IRQ        = |(status & mask);
endmodule : slpem_host
`default_nettype wire

// ---- slpem_if.sv ----
/*
 * slpem_if: register access path between the link controller and the
 * receiver parameter/error block, plus the decoder error events.
 * assumes: both ends on REF_CLK; read data one cycle after rd.
 */
`timescale 1ns/1ns
`default_nettype none
interface slpem_if
    import slpem_pkg::*;
();
    logic [AW-1:0]    addr;
    logic [DW-1:0]    wdata;
    logic             wr;
    logic             rd;
    logic [DW-1:0]    rdata;
    logic [LANES-1:0] err_disp;
    logic [LANES-1:0] err_nit;
    logic [LANES-1:0] err_ucc;
    logic             irq;

    modport dev (input addr, wdata, wr, rd, err_disp, err_nit, err_ucc,
                 output rdata, irq);
    modport host (output addr, wdata, wr, rd, input rdata, irq);
endinterface : slpem_if
`default_nettype wire

// ---- slpem_link_assertions.sv ----
/*
 * slpem_link_assertions: timing and read-value checks on the register link.
 * assumes: instantiated beside the link interface, one clock domain.
 */
`timescale 1ns/1ns
`default_nettype none
module slpem_link_assertions
    import slpem_pkg::*;
(
    // clock and reset
    input wire logic          REF_CLK,
    input wire logic          RST,
    // link signals
    input wire logic [AW-1:0] addr,
    input wire logic          wr,
    input wire logic          rd,
    input wire logic [DW-1:0] rdata,
    input wire logic          irq
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside answer cycle");
    a_csn_resv: assert property (rd && addr == ADDR_CSN |=> !rdata[5])
        else $error("reserved resolution bit reads one");
    a_hdcf_resv: assert property (rd && addr == ADDR_HDCF |=> rdata[6:5] == 2'h0)
        else $error("reserved density bits read nonzero");
    a_unmapped_zero: assert property (rd && addr[11:8] == 4'h1 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_flag_irq: assert property (rd && addr == ADDR_DISP ##1 rdata != 8'h00 |-> $past(irq))
        else $error("disparity flag set without irq");
    a_wr_single: assert property (wr |=> !wr)
        else $error("write strobe longer than one cycle");
    a_rd_single: assert property (rd |=> !rd)
        else $error("read strobe longer than one cycle");
    a_strobe_excl: assert property (!(wr && rd))
        else $error("read and write strobes together");
endmodule : slpem_link_assertions
`default_nettype wire

// ---- slpem_pkg.sv ----
/*
 * slpem_pkg: constants shared by the link parameter monitor ends.
 * assumes: byte-wide registers at their printed offsets, eight lanes.
 */
`default_nettype none
package slpem_pkg;
    localparam int LANES = 8;
    localparam int AW    = 12;
    localparam int DW    = 8;

    // device register offsets
    localparam logic [11:0] ADDR_CONV    = 12'h456;
    localparam logic [11:0] ADDR_CSN     = 12'h457;
    localparam logic [11:0] ADDR_NP      = 12'h458;
    localparam logic [11:0] ADDR_S       = 12'h459;
    localparam logic [11:0] ADDR_HDCF    = 12'h45a;
    localparam logic [11:0] ADDR_SPARE1  = 12'h45b;
    localparam logic [11:0] ADDR_SPARE2  = 12'h45c;
    localparam logic [11:0] ADDR_CHKSUM  = 12'h45d;
    localparam logic [11:0] ADDR_MON     = 12'h46b;
    localparam logic [11:0] ADDR_DESKEW  = 12'h46c;
    localparam logic [11:0] ADDR_DISP    = 12'h46d;
    localparam logic [11:0] ADDR_NIT     = 12'h46e;
    localparam logic [11:0] ADDR_UCC     = 12'h46f;
    localparam logic [11:0] ADDR_THRESH  = 12'h47c;
    localparam logic [11:0] ADDR_CKMODE  = 12'h300;
    localparam logic [11:0] ADDR_OCTETS  = 12'h454;

    // reset values
    localparam logic [7:0] RST_CONV   = 8'h01;
    localparam logic [7:0] RST_CSN    = 8'h0f;
    localparam logic [7:0] RST_NP     = 8'h2f;
    localparam logic [7:0] RST_S      = 8'h20;
    localparam logic [7:0] RST_HDCF   = 8'h80;
    localparam logic [7:0] RST_CHKSUM = 8'h45;
    localparam logic [7:0] RST_DESKEW = 8'h0f;
    localparam logic [7:0] RST_THRESH = 8'hff;
    localparam logic [7:0] RST_ZERO   = 8'h00;
    localparam logic [7:0] CNT_MAX    = 8'hff;

    // legal octets-per-frame codes, count minus one
    localparam logic [7:0] OCT_ONE    = 8'h00;
    localparam logic [7:0] OCT_TWO    = 8'h01;
    localparam logic [7:0] OCT_FOUR   = 8'h03;

    // field masks of writable bits
    localparam logic [7:0] MASK_CSN   = 8'hdf;
    localparam logic [7:0] MASK_HDCF  = 8'h9f;
    localparam logic [7:0] MASK_CTL   = 8'he7;

    // monitor select and error control field positions
    localparam int LSEL_LO = 4;
    localparam int LSEL_HI = 6;
    localparam int CSEL_LO = 0;
    localparam int CSEL_HI = 1;
    localparam int LADR_LO = 0;
    localparam int LADR_HI = 2;
    localparam int BIT_RST_IRQ  = 7;
    localparam int BIT_DIS_CNT  = 6;
    localparam int BIT_RST_CNT  = 5;
    localparam int BIT_CKMODE   = 6;

    // counter kinds
    typedef enum logic [1:0] {
        SLPEM_DISP = 2'h0,
        SLPEM_NIT  = 2'h1,
        SLPEM_UCC  = 2'h2
    } slpem_kind_t;
    localparam int KINDS = 3;

    // host-side register offsets
    localparam logic [3:0] H_CMD    = 4'h0;
    localparam logic [3:0] H_WDATA  = 4'h1;
    localparam logic [3:0] H_ADDR_L = 4'h2;
    localparam logic [3:0] H_ADDR_H = 4'h3;
    localparam logic [3:0] H_RDATA  = 4'h4;
    localparam logic [3:0] H_STATUS = 4'h5;
    localparam logic [3:0] H_MASK   = 4'h6;
    localparam logic [1:0] CMD_WR   = 2'h1;
    localparam logic [1:0] CMD_RD   = 2'h2;
endpackage : slpem_pkg
`default_nettype wire

// ---- tb.sv ----
/*
 * tb: drives the host software port, the device decoder error inputs,
 * and checks results read back across the link.
 * assumes: host and device joined by one link interface.
 */
`timescale 1ns/1ns
`default_nettype none
module tb
    import slpem_pkg::*;
;
    logic       ref_clk  = 1'b0;
    logic       rst      = 1'b1;
    logic [3:0] sw_addr  = 4'h0;
    logic [7:0] sw_wdata = 8'h00;
    logic       sw_wr    = 1'b0;
    logic       sw_rd    = 1'b0;
    wire  [7:0] sw_rdata;
    wire        irq;
    wire  [7:0] conv;
    wire  [7:0] deskew;
    wire        ck_mode;
    logic [1:0] hmask    = 2'h0;
    logic [7:0] r;
    int         miscompares     = 0;
    int         samples_checked = 0;
    int         cycles          = 0;
    ////////////////////////////////////////
    slpem_if i_slpem_if ();
    slpem_device i_slpem_device (.REF_CLK(ref_clk), .RST(rst), .LINK(i_slpem_if.dev),
        .CONV_MINUS_ONE(conv), .LANE_DESKEW(deskew), .CHECKSUM_MODE(ck_mode));
    slpem_host i_slpem_host (.REF_CLK(ref_clk), .RST(rst), .SW_ADDR(sw_addr),
        .SW_WDATA(sw_wdata), .SW_WR(sw_wr), .SW_RD(sw_rd), .SW_RDATA(sw_rdata),
        .IRQ(irq), .LINK(i_slpem_if.host));
    slpem_link_assertions i_slpem_link_assertions (.REF_CLK(ref_clk), .RST(rst),
        .addr(i_slpem_if.addr), .wr(i_slpem_if.wr), .rd(i_slpem_if.rd),
        .rdata(i_slpem_if.rdata), .irq(i_slpem_if.irq));
    ////////////////////////////////////////
    initial forever #20 ref_clk = ~ref_clk;
    // runs well under this; a hung poll lands here
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            test_done;
        end
    end
    ////////////////////////////////////////
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic sw_w(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
    endtask : sw_w
    task automatic sw_r(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge ref_clk);
        sw_rd <= 1'b0;
        @(negedge ref_clk);
        d = sw_rdata;
    endtask : sw_r
    // status poll, then irq level and one-to-clear
    task automatic wait_st(input logic [1:0] m);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 20 && (s[1:0] & m) == 2'h0; i++) sw_r(H_STATUS, s);
        chk({6'h0, s[1:0] & m}, {6'h0, m});
        chk({7'h0, irq}, {7'h0, |(hmask & m)});
        sw_w(H_STATUS, {6'h0, m});
        sw_r(H_STATUS, s);
        chk({6'h0, s[1:0] & m}, 8'h00);
        chk({7'h0, irq}, 8'h00);
    endtask : wait_st
    task automatic dev_a(input logic [11:0] a, input logic [1:0] c, input logic [7:0] d);
        sw_w(H_ADDR_L, a[7:0]);
        sw_w(H_ADDR_H, {4'h0, a[11:8]});
        sw_w(H_WDATA, d);
        sw_w(H_CMD, {6'h0, c});
        wait_st(c);
    endtask : dev_a
    task automatic rv(input logic [11:0] a, input logic [7:0] e);
        logic [7:0] d;
        dev_a(a, CMD_RD, 8'h00);
        sw_r(H_RDATA, d);
        chk(d, e);
    endtask : rv
    task automatic cfg(input logic [11:0] a, input logic [7:0] d, input logic [7:0] e);
        dev_a(a, CMD_WR, d);
        rv(a, e);
    endtask : cfg
    task automatic mon(input logic [1:0] k, input logic [2:0] ln, input logic [7:0] e);
        dev_a(ADDR_MON, CMD_WR, {1'b0, ln, 2'b00, k});
        rv(ADDR_MON, e);
    endtask : mon
    task automatic pulse(input int k, input logic [2:0] ln, input int n);
        logic [7:0] b;
        b = 8'h01 << ln;
        repeat (n) begin
            @(posedge ref_clk);
            if (k == 0) i_slpem_if.err_disp <= b;
            if (k == 1) i_slpem_if.err_nit <= b;
            if (k == 2) i_slpem_if.err_ucc <= b;
            @(posedge ref_clk);
            i_slpem_if.err_disp <= 8'h00;
            i_slpem_if.err_nit <= 8'h00;
            i_slpem_if.err_ucc <= 8'h00;
        end
    endtask : pulse
    ////////////////////////////////////////
    initial begin
        i_slpem_if.err_disp = 8'h00;
        i_slpem_if.err_nit = 8'h00;
        i_slpem_if.err_ucc = 8'h00;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rv(ADDR_CONV, 8'h01);
        rv(ADDR_CSN, 8'h0f);
        rv(ADDR_NP, 8'h2f);
        rv(ADDR_S, 8'h20);
        rv(ADDR_HDCF, 8'h80);
        rv(ADDR_CHKSUM, 8'h45);
        rv(ADDR_DESKEW, 8'h0f);
        rv(ADDR_SPARE1, 8'h00);
        rv(ADDR_OCTETS, 8'h00);
        chk(conv, 8'h01);
        chk(deskew, 8'h0f);
        $display("test reset values done");
        hmask = 2'h1;
        sw_w(H_MASK, 8'h01);
        cfg(ADDR_CONV, 8'h00, 8'h00);
        cfg(ADDR_CSN, 8'h2f, 8'h0f);
        cfg(ADDR_NP, 8'h0f, 8'h0f);
        cfg(ADDR_S, 8'h21, 8'h21);
        cfg(ADDR_HDCF, 8'he0, 8'h80);
        cfg(ADDR_CHKSUM, 8'ha5, 8'ha5);
        cfg(ADDR_DESKEW, 8'ha5, 8'ha5);
        cfg(ADDR_CKMODE, 8'h40, 8'h40);
        cfg(ADDR_OCTETS, 8'h03, 8'h03);
        cfg(ADDR_OCTETS, 8'h02, 8'h03);
        cfg(12'h123, 8'h55, 8'h00);
        chk(conv, 8'h00);
        chk(deskew, 8'ha5);
        chk({7'h0, ck_mode}, 8'h01);
        $display("test configuration done");
        hmask = 2'h0;
        sw_w(H_MASK, 8'h00);
        pulse(0, 3'd3, 2);
        pulse(1, 3'd2, 1);
        pulse(2, 3'd5, 3);
        mon(SLPEM_DISP, 3'd3, 8'h02);
        mon(SLPEM_NIT, 3'd2, 8'h01);
        mon(SLPEM_UCC, 3'd5, 8'h03);
        mon(SLPEM_DISP, 3'd2, 8'h00);
        mon(SLPEM_NIT, 3'd3, 8'h00);
        $display("test counters done");
        cfg(ADDR_THRESH, 8'h02, 8'h02);
        rv(ADDR_DISP, 8'h08);
        rv(ADDR_NIT, 8'h00);
        rv(ADDR_UCC, 8'h20);
        sw_r(H_STATUS, r);
        chk(r & 8'h04, 8'h04);
        dev_a(ADDR_DISP, CMD_WR, 8'h23);
        mon(SLPEM_DISP, 3'd3, 8'h00);
        dev_a(ADDR_DISP, CMD_WR, 8'h83);
        rv(ADDR_DISP, 8'h00);
        dev_a(ADDR_DISP, CMD_WR, 8'h43);
        pulse(0, 3'd3, 3);
        mon(SLPEM_DISP, 3'd3, 8'h00);
        mon(SLPEM_UCC, 3'd5, 8'h03);
        // count still at threshold on the clear edge: the set wins
        dev_a(ADDR_UCC, CMD_WR, 8'ha5);
        rv(ADDR_UCC, 8'h20);
        mon(SLPEM_UCC, 3'd5, 8'h00);
        dev_a(ADDR_UCC, CMD_WR, 8'h85);
        rv(ADDR_UCC, 8'h00);
        sw_r(H_STATUS, r);
        chk(r & 8'h04, 8'h00);
        pulse(1, 3'd0, 256);
        mon(SLPEM_NIT, 3'd0, 8'hff);
        rv(ADDR_NIT, 8'h01);
        mon(2'h3, 3'd0, 8'h00);
        dev_a(ADDR_NIT, CMD_WR, 8'h60);
        pulse(1, 3'd0, 1);
        mon(SLPEM_NIT, 3'd0, 8'h00);
        $display("test flags done");
        test_done;
    end
endmodule : tb
`default_nettype wire
